// File: hdl/srt_defs.vh
`ifndef SRT_DEFS_VH
`define SRT_DEFS_VH
// ----------------------------------------
// register offsets (word index)
// ----------------------------------------
`define SRT_OFS_OUT_NODES 2'h0
`define SRT_OFS_IN_NODES 2'h1
`define SRT_OFS_WAIT_TIME 2'h2
`define SRT_OFS_RESERVED 2'h3
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define SRT_RST_NODES 16'h0000
`define SRT_RST_WAIT 16'h0001
`define SRT_WAIT_MIN 16'h0001
`define SRT_WAIT_MAX 16'hFFDC
// ----------------------------------------
// timing: one wait unit in ns, clock period in ns
// ----------------------------------------
`define SRT_UNIT_NS 10000
`define SRT_CLK_NS 10
`define SRT_UNIT_CYC (`SRT_UNIT_NS / `SRT_CLK_NS)
// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define SRT_ST_DONE 0
`define SRT_ST_MISSING 8
`define SRT_ST_UNREG 9
`define SRT_ST_ERROR 15
`endif

// File: hdl/srt_slave_registration_tables.v
`timescale 1ns/1ns
`default_nettype none
`include "srt_defs.vh"

// Operation
// - output word bit n marks output node n (0..15) as expected
// - input word bit n marks input node n (0..15) as expected
// - both words are the reference list only while registration is enabled
// - wait word takes 0001..FFDC units; device waits that long before judging missing slaves
// - checking runs only when the enable switch is on
// - done flag when all registered joined in time; clear if none registered
// - missing flag after timeout, clears itself once offending slave joins
// - unregistered flag latches when a non-listed slave joins
module srt_slave_registration_tables #(
  parameter UNIT_CYC = `SRT_UNIT_CYC
) (
  // clock and control
  input wire sys_clk,
  input wire rst,
  input wire clk_en,
  input wire restart,
  input wire reg_enable,
  // register port
  input wire [1:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  // joined slaves from the network
  input wire [15:0] joined_output_nodes,
  input wire [15:0] joined_input_nodes,
  // status
  output reg [15:0] status_word,
  output reg [15:0] missing_output_nodes,
  output reg [15:0] missing_input_nodes,
  output reg [15:0] unreg_output_nodes,
  output reg [15:0] unreg_input_nodes
);

  // ----------------------------------------
  // sizes and state
  // ----------------------------------------
  localparam NODE_COUNT = 16;

  reg [15:0] expected_output_nodes_r;
  reg [15:0] expected_input_nodes_r;
  reg [15:0] join_wait_time_r;
  reg [31:0] unit_cnt_r;
  reg [15:0] wait_cnt_r;
  reg expired_r;
  reg done_r;
  reg [15:0] rdata_nxt;
  reg [15:0] status_nxt;
  wire [15:0] mis_o_nxt;
  wire [15:0] mis_i_nxt;
  wire [15:0] unr_o_nxt;
  wire [15:0] unr_i_nxt;
  wire [15:0] gap_o;
  wire [15:0] gap_i;
  wire restart_any;
  wire [15:0] wait_clip;
  wire unit_last;
  wire wait_last;
  wire all_joined;
  wire any_reg;
  wire check_on;
  wire done_now;
  wire miss_any;
  wire unreg_any;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // keep a wait word inside the legal span of units
  function [15:0] clamp_wait(input [15:0] raw);
    if (raw < `SRT_WAIT_MIN)
      clamp_wait = `SRT_WAIT_MIN;
    else if (raw > `SRT_WAIT_MAX)
      clamp_wait = `SRT_WAIT_MAX;
    else
      clamp_wait = raw;
  endfunction

  // listed nodes that are not present
  function [15:0] absent_nodes(input [15:0] listed, input [15:0] present);
    absent_nodes = listed & ~present;
  endfunction

  // ----------------------------------------
  // shared decode
  // ----------------------------------------
  assign restart_any = rst | restart;
  assign check_on = reg_enable;
  assign wait_clip = clamp_wait(join_wait_time_r);
  assign gap_o = absent_nodes(expected_output_nodes_r, joined_output_nodes);
  assign gap_i = absent_nodes(expected_input_nodes_r, joined_input_nodes);
  assign any_reg = |{expected_output_nodes_r, expected_input_nodes_r};
  assign all_joined = (gap_o == 16'h0000) && (gap_i == 16'h0000);
  assign done_now = check_on && !expired_r && any_reg && all_joined;
  assign unit_last = (unit_cnt_r >= UNIT_CYC - 1);
  assign wait_last = ((wait_cnt_r + 16'h0001) >= wait_clip);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      expected_output_nodes_r <= `SRT_RST_NODES;
      expected_input_nodes_r <= `SRT_RST_NODES;
      join_wait_time_r <= `SRT_RST_WAIT;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        `SRT_OFS_OUT_NODES: expected_output_nodes_r <= reg_wdata;
        `SRT_OFS_IN_NODES: expected_input_nodes_r <= reg_wdata;
        `SRT_OFS_WAIT_TIME: join_wait_time_r <= clamp_wait(reg_wdata);
        `SRT_OFS_RESERVED: ;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @* begin
    case (reg_addr)
      `SRT_OFS_OUT_NODES: rdata_nxt = expected_output_nodes_r;
      `SRT_OFS_IN_NODES: rdata_nxt = expected_input_nodes_r;
      `SRT_OFS_WAIT_TIME: rdata_nxt = join_wait_time_r;
      `SRT_OFS_RESERVED: rdata_nxt = 16'h0000;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // participation monitoring timer
  // ----------------------------------------
  // unit prescaler
  always @(posedge sys_clk) begin
    if (restart_any) begin
      unit_cnt_r <= 32'h00000000;
    end else if (clk_en && !expired_r) begin
      if (unit_last) begin
        unit_cnt_r <= 32'h00000000;
      end else begin
        unit_cnt_r <= unit_cnt_r + 32'h00000001;
      end
    end
  end

  // units elapsed since reset or restart
  always @(posedge sys_clk) begin
    if (restart_any) begin
      wait_cnt_r <= 16'h0000;
      expired_r <= 1'b0;
    end else if (clk_en && !expired_r && unit_last) begin
      if (wait_last) begin
        expired_r <= 1'b1;
      end else begin
        wait_cnt_r <= wait_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // per-node comparison
  // ----------------------------------------
  genvar node_i;
  generate
    for (node_i = 0; node_i < NODE_COUNT; node_i = node_i + 1) begin : g_node
      assign mis_o_nxt[node_i] = check_on & expired_r & gap_o[node_i];
      assign mis_i_nxt[node_i] = check_on & expired_r & gap_i[node_i];
      assign unr_o_nxt[node_i] = unreg_output_nodes[node_i] |
        (check_on & joined_output_nodes[node_i] & ~expected_output_nodes_r[node_i]);
      assign unr_i_nxt[node_i] = unreg_input_nodes[node_i] |
        (check_on & joined_input_nodes[node_i] & ~expected_input_nodes_r[node_i]);
    end
  endgenerate

  // ----------------------------------------
  // status word
  // ----------------------------------------
  assign miss_any = |{mis_o_nxt, mis_i_nxt};
  assign unreg_any = |{unr_o_nxt, unr_i_nxt};

  always @* begin
    status_nxt = 16'h0000;
    status_nxt[`SRT_ST_DONE] = done_r | done_now;
    status_nxt[`SRT_ST_MISSING] = miss_any;
    status_nxt[`SRT_ST_UNREG] = unreg_any;
    status_nxt[`SRT_ST_ERROR] = miss_any | unreg_any;
  end

  // ----------------------------------------
  // status registers
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (restart_any) begin
      done_r <= 1'b0;
      missing_output_nodes <= 16'h0000;
      missing_input_nodes <= 16'h0000;
      unreg_output_nodes <= 16'h0000;
      unreg_input_nodes <= 16'h0000;
      status_word <= 16'h0000;
    end else if (clk_en) begin
      if (done_now) begin
        done_r <= 1'b1;
      end
      missing_output_nodes <= mis_o_nxt;
      missing_input_nodes <= mis_i_nxt;
      unreg_output_nodes <= unr_o_nxt;
      unreg_input_nodes <= unr_i_nxt;
      status_word <= status_nxt;
    end
  end

endmodule
`default_nettype wire

// File: verification/srt_checker_sva.sv
`timescale 1ns/1ns
`default_nettype none
module srt_checker (
  // clock and control
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic clk_en,
  input wire logic reg_enable,
  // status outputs
  input wire logic [15:0] status_word,
  input wire logic [15:0] missing_output_nodes,
  input wire logic [15:0] missing_input_nodes,
  input wire logic [15:0] unreg_output_nodes,
  input wire logic [15:0] unreg_input_nodes
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst || restart);
  err_sum_a: assert property (status_word[15] == (status_word[8] | status_word[9])) else $error("err");
  miss_or_a: assert property (status_word[8] == |{missing_output_nodes, missing_input_nodes}) else $error("miss");
  unreg_or_a: assert property (status_word[9] == |{unreg_output_nodes, unreg_input_nodes}) else $error("unreg");
  done_keep_a: assert property (status_word[0] |=> status_word[0]) else $error("done");
  done_clean_a: assert property ($rose(status_word[0]) |-> !status_word[8]) else $error("done miss");
  uo_keep_a: assert property (1 |=> (~unreg_output_nodes & $past(unreg_output_nodes)) == 16'h0000) else $error("uo");
  ui_keep_a: assert property (1 |=> (~unreg_input_nodes & $past(unreg_input_nodes)) == 16'h0000) else $error("ui");
  miss_gone_a: assert property ($fell(status_word[8]) |-> {missing_output_nodes, missing_input_nodes} == 32'h00000000) else $error("gone");
  off_quiet_a: assert property ((clk_en && !reg_enable) |=> (missing_output_nodes == 16'h0000) && (missing_input_nodes == 16'h0000)) else $error("missing while off");
  off_nodone_a: assert property ((clk_en && !reg_enable && !status_word[0]) |=> !status_word[0]) else $error("done while off");
endmodule
bind srt_slave_registration_tables srt_checker chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .restart(restart),
  .clk_en(clk_en),
  .reg_enable(reg_enable),
  .status_word(status_word),
  .missing_output_nodes(missing_output_nodes),
  .missing_input_nodes(missing_input_nodes),
  .unreg_output_nodes(unreg_output_nodes),
  .unreg_input_nodes(unreg_input_nodes)
);
`default_nettype wire

// File: verification/srt_node_model.sv
`timescale 1ns/1ns
`default_nettype none
module srt_node_model (
  // clock
  input wire logic sys_clk,
  // slaves plugged in by the bench
  input wire logic [15:0] out_set,
  input wire logic [15:0] in_set,
  // slaves seen on the network
  output logic [15:0] joined_output_nodes,
  output logic [15:0] joined_input_nodes
);
  // plugged slaves join one cycle later
  always @(posedge sys_clk) begin
    joined_output_nodes <= out_set;
    joined_input_nodes <= in_set;
  end
endmodule
`default_nettype wire

// File: verification/srt_slave_registration_tables_bench.sv
`timescale 1ns/1ns
`default_nettype none
module srt_slave_registration_tables_bench;
  logic sys_clk = 0, rst = 1, restart = 0, reg_wr = 0, clk_en = 1, reg_enable = 1;
  logic [1:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, out_set = 0, in_set = 0, reg_rdata, status_word, joined_output_nodes;
  logic [15:0] joined_input_nodes, missing_output_nodes, missing_input_nodes, unreg_output_nodes, unreg_input_nodes;
  int n_mismatch = 0, checks_done = 0;
  always #5 sys_clk = ~sys_clk;
  srt_node_model nodes (
    .sys_clk(sys_clk),
    .out_set(out_set),
    .in_set(in_set),
    .joined_output_nodes(joined_output_nodes),
    .joined_input_nodes(joined_input_nodes)
  );
  srt_slave_registration_tables #(.UNIT_CYC(2)) dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .restart(restart),
    .reg_enable(reg_enable),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .joined_output_nodes(joined_output_nodes),
    .joined_input_nodes(joined_input_nodes),
    .status_word(status_word),
    .missing_output_nodes(missing_output_nodes),
    .missing_input_nodes(missing_input_nodes),
    .unreg_output_nodes(unreg_output_nodes),
    .unreg_input_nodes(unreg_input_nodes)
  );
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [1:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    {reg_addr, reg_wr, reg_wdata} = {a, 1'b1, d};
    @(negedge sys_clk);
    reg_wr = 0;
  endtask
  task rd(input logic [1:0] a, input logic [15:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    repeat (2) @(negedge sys_clk);
    chk("rdata", reg_rdata, e);
  endtask
  task rs(input int n);
    @(negedge sys_clk);
    restart = 1;
    @(negedge sys_clk);
    restart = 0;
    repeat (n) @(negedge sys_clk);
  endtask
  task wrap_up;
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    rst = 0;
    rd(2, 16'h0001);
    wr(2, 16'h0000);
    rd(2, 16'h0001);
    wr(2, 16'hFFFF);
    rd(2, 16'hFFDC);
    wr(0, 16'h0003);
    rd(0, 16'h0003);
    wr(1, 16'h0010);
    rd(1, 16'h0010);
    wr(2, 16'h0005);
    out_set = 16'h0013;
    rs(10);
    chk("status", status_word, 16'h8200);
    repeat (10) @(negedge sys_clk);
    chk("status", status_word, 16'h8300);
    chk("miss_in", missing_input_nodes, 16'h0010);
    chk("miss_out", missing_output_nodes, 16'h0000);
    chk("unreg_out", unreg_output_nodes, 16'h0010);
    {out_set, in_set} = {16'h0003, 16'h0010};
    repeat (4) @(negedge sys_clk);
    chk("status", status_word, 16'h8200);
    rs(20);
    chk("status", status_word, 16'h0001);
    {reg_enable, out_set, in_set} = {1'b0, 16'h0013, 16'h0020};
    rs(20);
    chk("status", status_word, 16'h0000);
    chk("unreg_in", unreg_input_nodes, 16'h0000);
    reg_enable = 1;
    repeat (2) @(negedge sys_clk);
    chk("status", status_word, 16'h8300);
    chk("unreg_in", unreg_input_nodes, 16'h0020);
    chk("miss_in", missing_input_nodes, 16'h0010);
    wr(0, 16'h0000);
    wr(1, 16'h0000);
    {out_set, in_set} = {16'h0000, 16'h0000};
    rs(20);
    chk("status", status_word, 16'h0000);
    wrap_up;
  end
endmodule
`default_nettype wire
